/* File: dcc_analog_model.sv */
// Analog comparator front end driving the raw decisions
`timescale 1ns/1ns
module dcc_analog_model
(
	input wire logic        sys_clk,
	input wire logic [1:0]  compEnable,
	input wire logic [15:0] vinMinus,
	input wire logic [15:0] vinPlus,
	output logic [1:0]      compRaw
);
	initial compRaw = 2'h0;
	always @(posedge sys_clk)
		for (int i = 0; i < 2; i++)
			compRaw[i] <= compEnable[i] ? vinMinus[8*i+:8] < vinPlus[8*i+:8] : ~compRaw[i];
endmodule

/* File: dcc_comparator_control.sv */
// Dual comparator control logic with AXI4-Lite register access
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module dcc_comparator_control
	import dcc_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_AW-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [1:0]            compRaw,
	input  wire logic                  timer1Tick,
	input  wire logic [1:0]            pinDirection,
	input  wire logic [1:0]            portLatch,
	output logic [1:0]                 compEnable,
	output logic [3:0]                 invertingInputSelect,
	output logic [1:0]                 referenceSelect,
	output logic [1:0]                 speedSelect,
	output logic [1:0]                 hysteresisEnable,
	output logic [1:0]                 referenceSourceSelect,
	output logic [1:0]                 pinOut,
	output logic [1:0]                 pinOutputEnable,
	output logic                       irq
);
	import dcc_pkg::*;

	logic [7:0]  ctrl_q [2];
	logic [7:0]  shared_q;
	logic [1:0]  rawSync1_q;
	logic [1:0]  rawSync2_q;
	logic [1:0]  tmrSample_q;
	logic [1:0]  result_q;
	logic [1:0]  resultPrev_q;
	logic [1:0]  irqFlag_q;
	logic [1:0]  irqEnable_q;
	logic [1:0]  irqPriority_q;
	logic [1:0]  resultD;
	logic [1:0]  irqSet;
	logic [1:0]  irqClr;
	logic        awHeld_q;
	logic        wHeld_q;
	logic [3:0]  awAddr_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic        doWrite;
	logic [7:0]  wByte;
	logic [7:0]  rdByte;
	logic        rdHit;

	function automatic logic [7:0] fnCtrlRead(input logic [7:0] c, input logic r);
		logic [7:0] v;
		v = c & CTRL_WMASK;
		v[BIT_RESULT] = r;
		return v;
	endfunction

	function automatic logic fnHit(input logic [3:0] a);
		return (a == ADDR_CTRL1) || (a == ADDR_CTRL2) || (a == ADDR_SHARED)
			|| (a == ADDR_IRQ_STAT);
	endfunction

	// AXI write path: address and data taken in any order
	assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
	assign wByte   = wStrb_q[0] ? wData_q[7:0] : 8'h00;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			awHeld_q      <= 1'b0;
			wHeld_q       <= 1'b0;
			awAddr_q      <= 4'h0;
			wData_q       <= 32'h0000_0000;
			wStrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= fnHit(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ctrl_q[0] <= CTRL_RESET;
			ctrl_q[1] <= CTRL_RESET;
			shared_q  <= SHARED_RESET;
		end
		else if (doWrite && wStrb_q[0])
		begin
			if (awAddr_q == ADDR_CTRL1)
				ctrl_q[0] <= wByte & CTRL_WMASK;
			if (awAddr_q == ADDR_CTRL2)
				ctrl_q[1] <= wByte & CTRL_WMASK;
			if (awAddr_q == ADDR_SHARED)
				shared_q <= wByte & SHARED_WMASK;
		end
	end

	// Pin-side raw results pass two flops first
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rawSync1_q <= 2'b00;
			rawSync2_q <= 2'b00;
		end
		else
		begin
			rawSync1_q <= compRaw;
			rawSync2_q <= rawSync1_q;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			tmrSample_q <= 2'b00;
		else if (timer1Tick)
			tmrSample_q <= rawSync2_q;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : gComp
			logic src;
			assign src = shared_q[BIT_SYNC1 - gi] ? tmrSample_q[gi] : rawSync2_q[gi];
			assign resultD[gi] = ctrl_q[gi][BIT_ENABLE] & (src ^ ctrl_q[gi][BIT_INVERT]);
			assign irqSet[gi] = result_q[gi] != resultPrev_q[gi];
			assign irqClr[gi] = doWrite && wStrb_q[0] && (awAddr_q == ADDR_IRQ_STAT)
				&& wData_q[gi];
		end
	endgenerate

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			result_q     <= 2'b00;
			resultPrev_q <= 2'b00;
		end
		else
		begin
			result_q     <= resultD;
			resultPrev_q <= result_q;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			irqFlag_q <= 2'b00;
		else
			irqFlag_q <= (irqFlag_q & ~irqClr) | irqSet;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			irqEnable_q   <= 2'b00;
			irqPriority_q <= 2'b00;
		end
		else if (doWrite && wStrb_q[1] && (awAddr_q == ADDR_IRQ_STAT))
		begin
			irqEnable_q   <= wData_q[9:8];
			irqPriority_q <= wData_q[9+IRQ_PRIO_LSB:8+IRQ_PRIO_LSB];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			irq <= 1'b0;
		else
			irq <= |((irqFlag_q & ~irqClr | irqSet) & irqEnable_q);
	end

	// Analog steering and pin drive
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			compEnable            <= 2'b00;
			invertingInputSelect  <= 4'h0;
			referenceSelect       <= 2'b00;
			speedSelect           <= 2'b11;
			hysteresisEnable      <= 2'b00;
			referenceSourceSelect <= 2'b00;
			pinOut                <= 2'b00;
			pinOutputEnable       <= 2'b00;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				compEnable[i]                 <= ctrl_q[i][BIT_ENABLE];
				invertingInputSelect[2*i +: 2] <= ctrl_q[i][BIT_CH_HI:0];
				referenceSelect[i]            <= ctrl_q[i][BIT_REF_SEL];
				speedSelect[i]                <= ctrl_q[i][BIT_SPEED];
				hysteresisEnable[i]           <= shared_q[BIT_HYS1 - i];
				referenceSourceSelect[i]      <= shared_q[BIT_RSEL1 - i];
				pinOut[i] <= ctrl_q[i][BIT_PIN_OE]
					? (ctrl_q[i][BIT_ENABLE] & resultD[i]) : portLatch[i];
				// Pin driven only when direction is output
				pinOutputEnable[i] <= !pinDirection[i];
			end
		end
	end

	// Read decode
	// Result in control and shared registers
	always_comb
	begin
		rdHit  = fnHit(s_axi_araddr);
		rdByte = 8'h00;
		unique case (s_axi_araddr)
			ADDR_CTRL1:    rdByte = fnCtrlRead(ctrl_q[0], result_q[0]);
			ADDR_CTRL2:    rdByte = fnCtrlRead(ctrl_q[1], result_q[1]);
			ADDR_SHARED:   rdByte = {result_q[0], result_q[1], shared_q[5:0]};
			ADDR_IRQ_STAT: rdByte = {6'h00, irqFlag_q};
			default:       rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
				s_axi_rdata  <= (s_axi_araddr == ADDR_IRQ_STAT)
					? {20'h00000, irqPriority_q, irqEnable_q, rdByte}
					: {24'h000000, rdByte};
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule

/* File: dcc_comparator_control_asserts.sv */
// Port-level assertions for the comparator control block
`timescale 1ns/1ns
module dcc_comparator_control_asserts
	import dcc_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  pinDirection,
	input wire logic [1:0]  portLatch,
	input wire logic [1:0]  compEnable,
	input wire logic [1:0]  speedSelect,
	input wire logic [1:0]  pinOut,
	input wire logic [1:0]  pinOutputEnable,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	speed_reset_a: assert property ($fell(srst) |-> speedSelect == 2'h3 && compEnable == 2'h0 && !irq)
		else $error("reset outputs wrong");
	pin_dir_a: assert property (!$past(srst) |-> pinOutputEnable == ~$past(pinDirection))
		else $error("pin enable not from direction");
	pin_latch_a: assert property (!compEnable[0] |->
		pinOut[0] == 1'b0 || pinOut[0] == $past(portLatch[0])) else $error("pin shows stale result");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_lat_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	unimpl_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0)
		else $error("unused bits not zero");
endmodule
bind dcc_comparator_control dcc_comparator_control_asserts chk_u (.sys_clk, .srst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .pinDirection, .portLatch, .compEnable, .speedSelect, .pinOut,
	.pinOutputEnable, .irq);

/* File: dcc_comparator_control_tb.sv */
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module dcc_comparator_control_tb;
	import dcc_pkg::*;
	logic sys_clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, timer1Tick = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF, invertingInputSelect;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [15:0] vinMinus = 0, vinPlus = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, compRaw, pinDirection = 0, portLatch = 0, compEnable;
	logic [1:0] referenceSelect, speedSelect, hysteresisEnable, referenceSourceSelect;
	logic [1:0] pinOut, pinOutputEnable;
	logic [7:0] v, x, y;
	logic c, p, r;
	logic [1:0] m = 2'h0;
	int error_cnt = 0, compares = 0, seed = 32'hAF5B;
	dcc_comparator_control dut_u (.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .compRaw, .timer1Tick, .pinDirection, .portLatch,
		.compEnable, .invertingInputSelect, .referenceSelect, .speedSelect, .hysteresisEnable,
		.referenceSourceSelect, .pinOut, .pinOutputEnable, .irq);
	dcc_analog_model pin_u (.sys_clk, .compEnable, .vinMinus, .vinPlus, .compRaw);
	initial forever #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) timer1Tick <= $random(seed);
	function automatic logic [31:0] ctrlExp(input logic [7:0] w, input logic raw);
		return {24'h0, w & CTRL_WMASK} | {24'h0, w[BIT_ENABLE] & (raw ^ w[BIT_INVERT]), 6'h0};
	endfunction
	task automatic wr(input logic [3:0] a, input logic [31:0] w, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK("bresp", er, s_axi_bresp)
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		`CHK("rresp", er, s_axi_rresp)
		if (er === RESP_OKAY) `CHK("rdata", e, d)
	endtask
	task automatic flip(input logic raw);
		@(posedge sys_clk);
		vinMinus[7:0] <= raw ? 8'h00 : 8'hFF;
		vinPlus[7:0] <= raw ? 8'hFF : 8'h00;
		repeat (8) @(posedge sys_clk);
	endtask
	task automatic report_and_stop;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#800000;
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		`CHK("speed", 2'h3, speedSelect)
		rd(ADDR_CTRL1, {24'h0, CTRL_RESET}, RESP_OKAY);
		rd(ADDR_SHARED, 32'h0, RESP_OKAY);
		rd(ADDR_IRQ_STAT, 32'h0, RESP_OKAY);
		wr(4'h2, 32'hFF, RESP_SLVERR);
		rd(4'h2, 32'h0, RESP_SLVERR);
		for (int i = 0; i < 20; i++)
		begin
			v = $random(seed);
			v[BIT_ENABLE] = 1'b0;
			wr(i[0] ? ADDR_CTRL2 : ADDR_CTRL1, {24'h0, v}, RESP_OKAY);
			rd(i[0] ? ADDR_CTRL2 : ADDR_CTRL1, ctrlExp(v, 1'b0), RESP_OKAY);
			`CHK("chsel", v[1:0], i[0] ? invertingInputSelect[3:2] : invertingInputSelect[1:0])
			`CHK("refsel", v[BIT_REF_SEL], referenceSelect[i[0]])
			`CHK("speedsel", v[BIT_SPEED], speedSelect[i[0]])
			`CHK("enable", 1'b0, compEnable[i[0]])
			wr(ADDR_SHARED, {24'h0, v & 8'hFC}, RESP_OKAY);
			rd(ADDR_SHARED, {24'h0, v & SHARED_WMASK & 8'hFC}, RESP_OKAY);
			`CHK("hys", {v[2], v[3]}, hysteresisEnable)
			`CHK("rsel", {v[4], v[5]}, referenceSourceSelect)
		end
		wr(ADDR_IRQ_STAT, 32'h300, RESP_OKAY);
		wr(ADDR_SHARED, 32'h0, RESP_OKAY);
		for (int k = 0; k < 8; k++)
		begin
			c = k[2];
			p = k[1];
			x = $random(seed);
			y = $random(seed);
			r = x < y;
			v = {3'b101, p, 4'b1000};
			m[c] = r ^ p;
			@(posedge sys_clk);
			vinMinus[8*c+:8] <= x;
			vinPlus[8*c+:8] <= y;
			portLatch <= $random(seed);
			wr(c ? ADDR_CTRL2 : ADDR_CTRL1, {24'h0, v}, RESP_OKAY);
			repeat (8) @(posedge sys_clk);
			rd(c ? ADDR_CTRL2 : ADDR_CTRL1, ctrlExp(v, r), RESP_OKAY);
			rd(ADDR_SHARED, {24'h0, m[0], m[1], 6'h0}, RESP_OKAY);
			`CHK("pin", r ^ p, pinOut[c])
			`CHK("pinoe", 2'h3, pinOutputEnable)
		end
		flip(1'b1);
		wr(ADDR_IRQ_STAT, 32'h303, RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		`CHK("irq", 1'b0, irq)
		flip(1'b0);
		`CHK("irq", 1'b1, irq)
		rd(ADDR_IRQ_STAT, 32'h301, RESP_OKAY);
		wr(ADDR_IRQ_STAT, 32'h003, RESP_OKAY);
		flip(1'b1);
		`CHK("irq", 1'b0, irq)
		rd(ADDR_IRQ_STAT, 32'h001, RESP_OKAY);
		wr(ADDR_CTRL1, 32'h88, RESP_OKAY);
		@(posedge sys_clk);
		pinDirection <= 2'h1;
		repeat (3) @(posedge sys_clk);
		`CHK("latch", portLatch[0], pinOut[0])
		`CHK("pinoe", 2'h2, pinOutputEnable)
		report_and_stop();
	end
endmodule

/* File: dcc_pkg.sv */
// Register map, field positions and reset values of the comparator control block
package dcc_pkg;
	localparam int          AXI_AW          = 4;
	// Byte addresses of the registers
	localparam logic [3:0]  ADDR_CTRL1      = 4'h0;
	localparam logic [3:0]  ADDR_CTRL2      = 4'h4;
	localparam logic [3:0]  ADDR_SHARED     = 4'h8;
	localparam logic [3:0]  ADDR_IRQ_STAT   = 4'hC;
	// Interrupt status/mask/priority share one layout; priority sits at bits 11:10
	localparam int          IRQ_PRIO_LSB    = 2;
	// Comparator control fields
	localparam int          BIT_ENABLE      = 7;
	localparam int          BIT_RESULT      = 6;
	localparam int          BIT_PIN_OE      = 5;
	localparam int          BIT_INVERT      = 4;
	localparam int          BIT_SPEED       = 3;
	localparam int          BIT_REF_SEL     = 2;
	localparam int          BIT_CH_HI       = 1;
	// Shared register fields
	localparam int          BIT_MIRROR1     = 7;
	localparam int          BIT_MIRROR2     = 6;
	localparam int          BIT_RSEL1       = 5;
	localparam int          BIT_HYS1        = 3;
	localparam int          BIT_SYNC1       = 1;
	// Writable masks, reset values and AXI response codes
	localparam logic [7:0]  CTRL_WMASK      = 8'hBF;
	localparam logic [7:0]  CTRL_RESET      = 8'h08;
	localparam logic [7:0]  SHARED_WMASK    = 8'h3F;
	localparam logic [7:0]  SHARED_RESET    = 8'h00;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage
